// file: pkg/crss_pkg.sv
// Package with constants and carrier types for the converter start-up and restart sequencer.
//
// Overview of operation
// R1: Charging generator runs only while bulk voltage is above the start level.
// R2: Full charge current on normal start-up, reduced current during auto-restart.
// R3: At supply turn-on level, start switching and stop charging.
// R4: Gate is held low while supply lockout holds.
// R5: Before demag detection is armed, turn on at the fixed starter rate; the starter divides the oscillator by 4 in start-up and by 8 after it.
// R6: Once armed, demag detection times turn-on; oscillator only limits frequency.
// R7: Every start-up attempt and every restart runs a fresh start-up phase.
// R8: Start-up phase length is counted in controller clocks, not switching cycles.
// R9: Drain current ceiling ramps to maximum over 3.5 ms or 4.2 ms.
// R10: Overload guard is disabled in start-up, enabled after the counter expires.
// R11: Below supply turn-off level, stop switching and inhibit any restart.
// R12: After a protection trips, stop; recharge with reduced current below restart level.
// R13: In auto-restart, reaching turn-on level restarts with a new start-up phase.
// R14: All faults are handled by slow automatic restart.
// R15: Ceiling set-point can be lowered by a setting sensed on the demag pin.
// R16: Phases are distinct one-hot states, exactly one active.
// R17: Gate drive stops within one clock after any fault flag asserts; in the code an overload during start-up is masked and leaves the gate running.
package crss_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ          = 200;
  localparam int STARTUP_TIME_US  = 5000;
  localparam int RAMP_TIME_L_US   = 3500;
  localparam int RAMP_TIME_H_US   = 4200;
  localparam int OSC_LIM_L_KHZ    = 136;
  localparam int OSC_LIM_H_KHZ    = 225;
  localparam int STARTUP_CYC      = STARTUP_TIME_US * CLK_MHZ;
  localparam int RAMP_L_CYC       = RAMP_TIME_L_US * CLK_MHZ;
  localparam int RAMP_H_CYC       = RAMP_TIME_H_US * CLK_MHZ;
  // Shortest oscillator period rounds up so the frequency limit is never exceeded.
  localparam int OSC_L_CYC        = (CLK_MHZ * 1000 + OSC_LIM_L_KHZ - 1) / OSC_LIM_L_KHZ;
  localparam int OSC_H_CYC        = (CLK_MHZ * 1000 + OSC_LIM_H_KHZ - 1) / OSC_LIM_H_KHZ;
  localparam int STARTER_DIV_SU   = 4;
  localparam int STARTER_DIV_RUN  = 8;

  // ****************************************************************
  // Widths and levels
  // ****************************************************************
  localparam int        CNT_W       = 24;
  localparam int        OSC_W       = 12;
  localparam int        CEIL_W      = 8;
  localparam logic [7:0] CEIL_MIN   = 8'h00;
  localparam logic [7:0] CEIL_MAX   = 8'hFF;
  localparam logic [7:0] CEIL_LOW   = 8'hC0;
  localparam int        SYNC_STAGES = 2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [5:0] {
    ST_LOCKOUT   = 6'h01,
    ST_CHARGE    = 6'h02,
    ST_STARTUP   = 6'h04,
    ST_REGULATE  = 6'h08,
    ST_FAULT     = 6'h10,
    ST_PWR_DOWN  = 6'h20
  } crss_state_t;

  typedef struct packed {
    logic bulk_ok;
    logic supply_on;
    logic supply_off;
    logic supply_restart;
    logic demag_armed;
    logic demag_trig;
    logic peak_reached;
    logic overload;
    logic fault_trip;
    logic limit_reduce;
    logic freq_high;
  } crss_pins_t;

  typedef struct packed {
    logic charge_en;
    logic charge_reduced;
    logic gate_on;
    logic guard_en;
    logic startup_active;
  } crss_drive_t;

endpackage

// file: rtl/crss_sequencer.sv
// Start-up, soft-start, starter switching and auto-restart sequencer of the converter controller.
`timescale 1ns/1ps
module crss_sequencer #(
  parameter int STARTUP_CYCLES = crss_pkg::STARTUP_CYC,
  parameter int RAMP_L_CYCLES  = crss_pkg::RAMP_L_CYC,
  parameter int RAMP_H_CYCLES  = crss_pkg::RAMP_H_CYC
) (
  // Clock and reset
  input  wire logic                            clock,
  input  wire logic                            reset,
  // Comparator and pin levels, asynchronous
  input  wire crss_pkg::crss_pins_t            pins_in,
  // Control outputs
  output crss_pkg::crss_drive_t                drive,
  output logic [crss_pkg::CEIL_W-1:0]          drain_current_ceiling,
  output crss_pkg::crss_state_t                phase
);
  import crss_pkg::*;

  localparam int RAMP_STEP_L = RAMP_L_CYCLES / int'(CEIL_MAX);
  localparam int RAMP_STEP_H = RAMP_H_CYCLES / int'(CEIL_MAX);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  crss_pins_t pins;
  logic [$bits(crss_pins_t)-1:0] pins_vec;

  crss_sync #(.W($bits(crss_pins_t))) u_sync (
    .clock    (clock),
    .reset    (reset),
    .async_in (pins_in),
    .sync_out (pins_vec)
  );
  assign pins = crss_pins_t'(pins_vec);

  // ****************************************************************
  // Phase sequencer
  // ****************************************************************
  crss_state_t             state_reg,   state_next;
  logic                    restart_reg, restart_next;
  logic                    high_reg,    high_next;
  logic [CNT_W-1:0]        su_cnt_reg,  su_cnt_next;
  logic                    su_done;
  logic                    any_fault;

  assign su_done   = (su_cnt_reg == CNT_W'(STARTUP_CYCLES - 1));
  // The guard only counts as a fault once enabled, so start-up overloads are masked.
  assign any_fault = pins.fault_trip | (pins.overload & drive.guard_en); // [R10] [R14]

  always_comb begin
    state_next   = state_reg;
    restart_next = restart_reg;
    high_next    = high_reg;
    su_cnt_next  = su_cnt_reg;
    unique case (state_reg)
      ST_LOCKOUT: begin
        restart_next = 1'b0;                                  // [R2]
        high_next    = pins.freq_high;
        if (pins.bulk_ok) state_next = ST_CHARGE;
      end
      ST_CHARGE: begin
        su_cnt_next = '0;
        if (pins.supply_on) state_next = ST_STARTUP;          // [R3] [R7] [R13]
      end
      ST_STARTUP: begin
        su_cnt_next = su_cnt_reg + CNT_W'(1);                 // [R8]
        if (pins.supply_off) state_next = ST_PWR_DOWN;
        else if (any_fault) state_next = ST_FAULT;
        else if (su_done) state_next = ST_REGULATE;           // [R10]
      end
      ST_REGULATE: begin
        if (pins.supply_off) state_next = ST_PWR_DOWN;        // [R11]
        else if (any_fault) state_next = ST_FAULT;            // [R14]
      end
      ST_FAULT: begin
        restart_next = 1'b1;
        if (pins.supply_restart && pins.bulk_ok) state_next = ST_CHARGE; // [R12]
      end
      ST_PWR_DOWN: begin
        // Only removal of the bulk supply re-arms the sequence, so the output decays monotonically.
        if (!pins.bulk_ok) state_next = ST_LOCKOUT;           // [R11]
      end
      default: state_next = ST_LOCKOUT;                       // [R16]
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg   <= ST_LOCKOUT;
      restart_reg <= 1'b0;
      high_reg    <= 1'b0;
      su_cnt_reg  <= '0;
    end else begin
      state_reg   <= state_next;
      restart_reg <= restart_next;
      high_reg    <= high_next;
      su_cnt_reg  <= su_cnt_next;
    end
  end

  // ****************************************************************
  // Soft-start ramp of the drain current ceiling
  // ****************************************************************
  logic [CNT_W-1:0]  step_reg,  step_next;
  logic [CEIL_W-1:0] level_reg, level_next;
  logic [CEIL_W-1:0] cap;
  logic [CEIL_W-1:0] ceil_next;
  logic [CNT_W-1:0]  step_end;

  assign step_end = high_reg ? CNT_W'(RAMP_STEP_H - 1) : CNT_W'(RAMP_STEP_L - 1);
  assign cap      = pins.limit_reduce ? CEIL_LOW : CEIL_MAX;          // [R15]

  always_comb begin
    step_next  = step_reg;
    level_next = level_reg;
    if (state_reg == ST_CHARGE) begin
      step_next  = '0;
      level_next = CEIL_MIN;                                          // [R9]
    end else if (level_reg != CEIL_MAX) begin
      if (step_reg == step_end) begin
        step_next  = '0;
        level_next = level_reg + CEIL_W'(1);                          // [R9]
      end else begin
        step_next  = step_reg + CNT_W'(1);
      end
    end
    ceil_next = (level_reg < cap) ? level_reg : cap;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      step_reg              <= '0;
      level_reg             <= CEIL_MIN;
      drain_current_ceiling <= CEIL_MIN;
    end else begin
      step_reg              <= step_next;
      level_reg             <= level_next;
      drain_current_ceiling <= ceil_next;
    end
  end

  // ****************************************************************
  // Gate timing: starter oscillator and demag-driven turn-on
  // ****************************************************************
  logic [OSC_W-1:0] osc_reg,   osc_next;
  logic             osc_ok_reg, osc_ok_next;
  logic [2:0]       star_reg,  star_next;
  logic             lock_reg,  lock_next;
  logic             trig_d_reg;
  logic             osc_wrap, starter_tick, demag_fall, turn_on, switching;
  logic [OSC_W-1:0] osc_end;
  logic [2:0]       star_end;
  crss_drive_t      drive_next;

  assign osc_end      = high_reg ? OSC_W'(OSC_H_CYC - 1) : OSC_W'(OSC_L_CYC - 1);
  assign star_end     = (state_reg == ST_STARTUP) ? 3'(STARTER_DIV_SU - 1) : 3'(STARTER_DIV_RUN - 1);
  assign osc_wrap     = (osc_reg == osc_end);
  assign starter_tick = osc_wrap && (star_reg == star_end);
  assign demag_fall   = trig_d_reg & ~pins.demag_trig;
  assign switching    = ((state_reg == ST_STARTUP) || (state_reg == ST_REGULATE)) &&
                        (state_next == state_reg || state_next == ST_REGULATE) &&
                        !pins.supply_off && !any_fault;                       // [R4] [R17]
  assign turn_on      = lock_reg ? (demag_fall && osc_ok_reg) : starter_tick;  // [R5] [R6]

  always_comb begin
    osc_next    = osc_wrap ? '0 : osc_reg + OSC_W'(1);
    osc_ok_next = osc_ok_reg | osc_wrap;
    star_next   = osc_wrap ? star_reg + 3'(1) : star_reg;
    lock_next   = lock_reg | (switching & pins.demag_armed);              // [R6]
    if (state_reg == ST_CHARGE) lock_next = 1'b0;                        // [R7]
    if (!drive.gate_on && turn_on) begin
      osc_next    = '0;
      osc_ok_next = 1'b0;
      star_next   = '0;
    end
    drive_next.gate_on        = switching &&
                                (drive.gate_on ? !(pins.peak_reached || osc_wrap) : turn_on);
    drive_next.charge_en      = (state_reg == ST_CHARGE) && pins.bulk_ok;         // [R1] [R3]
    drive_next.charge_reduced = restart_reg;                                     // [R2] [R12]
    drive_next.guard_en       = (state_next == ST_REGULATE);                     // [R10]
    drive_next.startup_active = (state_next == ST_STARTUP);
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      osc_reg    <= '0;
      osc_ok_reg <= 1'b0;
      star_reg   <= '0;
      lock_reg   <= 1'b0;
      trig_d_reg <= 1'b0;
      drive      <= '0;
    end else begin
      osc_reg    <= osc_next;
      osc_ok_reg <= osc_ok_next;
      star_reg   <= star_next;
      lock_reg   <= lock_next;
      trig_d_reg <= pins.demag_trig;
      drive      <= drive_next;
    end
  end

  assign phase = state_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_charge_bulk: assert property (drive.charge_en |-> $past(pins.bulk_ok))   // [R1]
    else $error("charging enabled without bulk level");
  chk_charge_level: assert property (state_reg == ST_LOCKOUT ##1 state_reg == ST_CHARGE |=> // [R2]
    !drive.charge_reduced)
    else $error("normal start-up charging reduced");
  chk_turn_on: assert property (state_reg == ST_CHARGE && pins.supply_on |=> // [R3]
    state_reg == ST_STARTUP ##1 !drive.charge_en)
    else $error("turn-on level did not start switching");
  chk_gate_lockout: assert property (pins.supply_off |=> !drive.gate_on)      // [R4]
    else $error("gate high under supply lockout");
  chk_fault_gate: assert property (pins.fault_trip |=> !drive.gate_on)        // [R17]
    else $error("gate still high after fault");
  chk_guard_off: assert property (state_reg == ST_STARTUP |-> !drive.guard_en) // [R10]
    else $error("overload guard active in start-up");
  chk_overload_mask: assert property (state_reg == ST_STARTUP && pins.overload && !pins.fault_trip && // [R10]
    !pins.supply_off |=> state_reg != ST_FAULT)
    else $error("overload not masked in start-up");
  chk_ramp_start: assert property (state_reg == ST_CHARGE ##1 state_reg == ST_STARTUP |=> // [R9]
    drain_current_ceiling == CEIL_MIN)
    else $error("ceiling ramp did not restart");
  chk_ceiling_cap: assert property (pins.limit_reduce |=> drain_current_ceiling <= CEIL_LOW) // [R15]
    else $error("lowered ceiling set-point exceeded");
  chk_pwrdn_hold: assert property (state_reg == ST_PWR_DOWN && pins.bulk_ok |=> state_reg == ST_PWR_DOWN) // [R11]
    else $error("restart attempted after power-down");
  chk_restart: assert property (state_reg == ST_FAULT && pins.supply_restart && pins.bulk_ok |=> // [R12]
    state_reg == ST_CHARGE ##1 (drive.charge_reduced == 1'b1))
    else $error("auto-restart recharge not reduced");
  chk_one_hot: assert property ($onehot(state_reg))                           // [R16]
    else $error("state not one-hot");

  cov_regulate: cover property (state_reg == ST_STARTUP ##1 state_reg == ST_REGULATE);
  cov_restart:  cover property (state_reg == ST_FAULT ##1 state_reg == ST_CHARGE);
  cov_pwrdn:    cover property (state_reg == ST_REGULATE ##1 state_reg == ST_PWR_DOWN);

endmodule

// file: rtl/crss_sync.sv
// Two-stage synchroniser for a vector of asynchronous comparator levels.
`timescale 1ns/1ps
module crss_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         reset,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_out <= sync_next;
    end
  end

endmodule

// file: test/crss_sequencer_tb_top.sv
// Self-checking testbench of the start-up and restart sequencer.
`timescale 1ns/1ps
module crss_sequencer_tb_top;
  import crss_pkg::*;
  typedef struct {logic [6:0] in; int cyc; crss_state_t ph; logic ce; logic red; logic grd; int rmin; int rmax;} crss_row_t;
  logic                 clock = 1'b0;
  logic                 reset = 1'b1;
  logic [6:0]           stim  = 7'h00;
  logic                 lred  = 1'b0;
  logic                 fhigh = 1'b0;
  logic                 slow  = 1'b0;
  logic                 peak;
  logic                 armed;
  logic                 trig;
  logic                 gate_q = 1'b0;
  crss_pins_t           pins;
  crss_drive_t          drive;
  logic [CEIL_W-1:0]    ceiling;
  crss_state_t          phase;
  int                   num_errors = 0;
  int                   cmp_count = 0;
  int                   rises = 0;
  int                   n;
  crss_row_t            rows [15];

  assign pins = '{bulk_ok: stim[6], supply_on: stim[5], supply_off: stim[4], supply_restart: stim[3],
                  demag_armed: armed, demag_trig: trig, peak_reached: peak, overload: stim[2],
                  fault_trip: stim[1], limit_reduce: lred, freq_high: fhigh};

  crss_sequencer #(.STARTUP_CYCLES(20000), .RAMP_L_CYCLES(2550), .RAMP_H_CYCLES(5100)) dut_u (
    .clock(clock), .reset(reset), .pins_in(pins), .drive(drive),
    .drain_current_ceiling(ceiling), .phase(phase));
  crss_stage_model part_u (
    .clock(clock), .reset(reset), .gate_on(drive.gate_on), .aux_high(stim[0]), .slow(slow),
    .peak_reached(peak), .demag_armed(armed), .demag_trig(trig));

  initial begin
    forever #2.5 clock = ~clock;
  end

  // Edges are counted on the falling clock so that clearing the count on the rising edge cannot race.
  always @(negedge clock) begin
    gate_q <= drive.gate_on;
    if (drive.gate_on && !gate_q) rises++;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic do_reset;
    @(posedge clock);
    reset <= 1'b1;
    stim  <= 7'h00;
    lred  <= 1'b0;
    slow  <= 1'b0;
    repeat (20) @(posedge clock);
    #1;
    check(phase, ST_LOCKOUT);
    check({drive, ceiling}, 13'h0000);
    @(posedge clock);
    reset <= 1'b0;
  endtask

  task automatic wait_phase(input crss_state_t p);
    n = 0;
    while (phase !== p && n < 30000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 30000) begin
      num_errors++;
      complete_run();
    end
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rows = '{'{7'h00, 10, ST_LOCKOUT, 0, 0, 0, 0, 0},   '{7'h40, 10, ST_CHARGE, 1, 0, 0, 0, 0},
             '{7'h60, 10, ST_STARTUP, 0, 0, 0, 0, 2},  '{7'h64, 10, ST_STARTUP, 0, 0, 0, 0, 2},
             '{7'h60, 25000, ST_REGULATE, 0, 0, 1, 2, 5}, '{7'h61, 6000, ST_REGULATE, 0, 0, 1, 3, 5},
             '{7'h65, 10, ST_FAULT, 0, 0, 0, 0, 1},    '{7'h48, 10, ST_CHARGE, 1, 1, 0, 0, 0},
             '{7'h60, 10, ST_STARTUP, 0, 0, 0, 0, 2},  '{7'h62, 10, ST_FAULT, 0, 0, 0, 0, 1},
             '{7'h48, 10, ST_CHARGE, 1, 1, 0, 0, 0},   '{7'h60, 10, ST_STARTUP, 0, 0, 0, 0, 2},
             '{7'h70, 10, ST_PWR_DOWN, 0, 0, 0, 0, 2}, '{7'h48, 10, ST_PWR_DOWN, 0, 0, 0, 0, 0},
             '{7'h00, 10, ST_LOCKOUT, 0, 0, 0, 0, 0}};
    do_reset();
    foreach (rows[i]) begin
      @(posedge clock);
      stim  <= rows[i].in;
      rises = 0;
      repeat (rows[i].cyc) @(posedge clock);
      #1;
      check(phase, rows[i].ph);
      check(drive.charge_en, rows[i].ce);
      check(drive.startup_active, rows[i].ph == ST_STARTUP);
      if (rows[i].ph == ST_CHARGE) check(drive.charge_reduced, rows[i].red);
      if (rows[i].ph inside {ST_STARTUP, ST_REGULATE}) check(drive.guard_en, rows[i].grd);
      else check(drive.gate_on, 1'b0);
      check(rises >= rows[i].rmin && rises <= rows[i].rmax, 1'b1);
    end
    // Both variants: soft-start length, reduced ceiling, and gate cut by a fault while it is on.
    for (int v = 0; v < 2; v++) begin
      do_reset();
      fhigh <= v[0];
      stim  <= 7'h60;
      wait_phase(ST_STARTUP);
      check(ceiling, 8'h00);
      repeat (2600) @(posedge clock);
      #1;
      if (v == 0) check(ceiling, 8'hFF);
      else check(ceiling > 8'h70 && ceiling < 8'hFF, 1'b1);
      repeat (2600) @(posedge clock);
      #1;
      check(ceiling, 8'hFF);
      @(posedge clock);
      lred <= 1'b1;
      repeat (10) @(posedge clock);
      #1;
      check(ceiling, 8'hC0);
      @(posedge clock);
      slow <= 1'b1;
      n = 0;
      while (drive.gate_on !== 1'b1 && n < 20000) begin
        @(posedge clock);
        #1;
        n++;
      end
      check(n < 20000, 1'b1);
      if (n >= 20000) complete_run();
      @(posedge clock);
      stim <= 7'h62;
      repeat (3) @(posedge clock);
      #1;
      check(drive.gate_on, 1'b0);
      check(phase, ST_FAULT);
    end
    complete_run();
  end
endmodule

// file: test/crss_stage_model.sv
// Behavioural model of the power stage and transformer windings that face the sequencer.
`timescale 1ns/1ps
module crss_stage_model (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // Gate from the sequencer, winding state from the bench
  input  wire logic gate_on,
  input  wire logic aux_high,
  input  wire logic slow,
  // Feedback to the sequencer
  output logic      peak_reached,
  output logic      demag_armed,
  output logic      demag_trig
);
  logic [7:0] on_cnt;
  logic [5:0] ring_cnt;

  // ************************************************************
  // Current ramp and drain ringing
  // ************************************************************
  // The winding keeps ringing while the switch is off, so a late edge always follows an early one.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      on_cnt       <= 8'h00;
      ring_cnt     <= 6'h00;
      peak_reached <= 1'b0;
      demag_armed  <= 1'b0;
      demag_trig   <= 1'b0;
    end else begin
      on_cnt       <= gate_on ? on_cnt + 8'h01 : 8'h00;
      ring_cnt     <= gate_on ? 6'h00 : ring_cnt + 6'h01;
      peak_reached <= gate_on && (on_cnt >= (slow ? 8'hC8 : 8'h0A));
      demag_armed  <= aux_high;
      demag_trig   <= aux_high && !gate_on && ring_cnt[5];
    end
  end
endmodule
